// ==== src/fpmdc_top.sv ====
// Fault-pin mask and device configuration register bank with fault pin gating.
`timescale 1ns/10ps
module fpmdc_top (
   input  wire logic        i_clk,        // 250 MHz main clock.
   input  wire logic        i_rstn,       // Async reset, active low.
   input  wire logic        i_wr,         // Register write strobe.
   input  wire logic        i_rd,         // Register read strobe.
   input  wire logic [7:0]  i_addr,       // Register address.
   input  wire logic [15:0] i_wdata,      // Write data.
   input  wire logic [7:0]  i_flags,      // Summary flags, bit7 supply .. bit0 access, high = active.
   input  wire logic        i_fault_mode, // Shared pin two configured as fault output.
   input  wire logic        i_drdy_a,     // Data ready from converter a, high = ready.
   input  wire logic        i_drdy_b,     // Data ready from converter b, high = ready.
   output logic [15:0]      o_rdata,      // Read data, registered.
   output logic             o_rvalid,     // Read data valid pulse.
   output logic             o_fault,      // Fault pin level, high = fault.
   output logic             o_drdy,       // Selected data ready, high = ready.
   output logic             o_clk_ext,    // One selects the external main clock.
   output logic             o_word32,     // One selects 32-bit words.
   output logic [2:0]       o_state       // One-hot operating state.
);
   logic [15:0]                       mask_q;
   logic [15:0]                       cfg_q;
   logic [15:0]                       rdata_d;
   logic                              mask_we;
   logic                              cfg_we;
   logic [fpmdc_pkg::FPMDC_NFLAG-1:0] mask_fld;
   logic [fpmdc_pkg::FPMDC_NFLAG-1:0] live_flags;
   fpmdc_pkg::fpmdc_state_t           state_d;

   // ======================================================
   // Address decode
   // One decoder serves the write strobes and the read mux, so both always agree on the map.
   function automatic logic fpmdc_hit(input logic [7:0] addr, input logic [7:0] base);
      return addr == base;
   endfunction

   assign mask_we = i_wr && fpmdc_hit(i_addr, fpmdc_pkg::FPMDC_ADDR_MASK);
   assign cfg_we  = i_wr && fpmdc_hit(i_addr, fpmdc_pkg::FPMDC_ADDR_CFG);

   // ======================================================
   // Registers
   fpmdc_reg #(
      .RST   (fpmdc_pkg::FPMDC_RST_MASK),
      .WMASK (fpmdc_pkg::FPMDC_WMASK_MASK)
   ) u_mask (
      .i_clk   (i_clk),
      .i_rstn  (i_rstn),
      .i_we    (mask_we),
      .i_wdata (i_wdata),
      .o_q     (mask_q)
   );

   fpmdc_reg #(
      .RST   (fpmdc_pkg::FPMDC_RST_CFG),
      .WMASK (fpmdc_pkg::FPMDC_WMASK_CFG)
   ) u_cfg (
      .i_clk   (i_clk),
      .i_rstn  (i_rstn),
      .i_we    (cfg_we),
      .i_wdata (i_wdata),
      .o_q     (cfg_q)
   );

   // ======================================================
   // Read port
   // Unmapped addresses read zero, so a host that strays off the map sees no stale data.
   always_comb begin
      rdata_d = 16'h0000;
      if (fpmdc_hit(i_addr, fpmdc_pkg::FPMDC_ADDR_MASK)) begin
         rdata_d = mask_q;
      end else if (fpmdc_hit(i_addr, fpmdc_pkg::FPMDC_ADDR_CFG)) begin
         rdata_d = cfg_q;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rdata  <= 16'h0000;
         o_rvalid <= 1'b0;
      end else begin
         o_rdata  <= i_rd ? rdata_d : 16'h0000;
         o_rvalid <= i_rd;
      end
   end

   // ======================================================
   // Fault pin gating
   // Flag i pairs with mask bit i plus the field base; one gate per flag.
   assign mask_fld = mask_q[fpmdc_pkg::FPMDC_FLAG_LO +: fpmdc_pkg::FPMDC_NFLAG];

   for (genvar g = 0; g < fpmdc_pkg::FPMDC_NFLAG; g++) begin : g_gate
      assign live_flags[g] = i_flags[g] & ~mask_fld[g];
   end

   // The pin is registered, so a flag reaches it one clock after it rises.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_fault <= 1'b0;
      end else begin
         o_fault <= i_fault_mode && (|live_flags);
      end
   end

   // ======================================================
   // Configuration outputs
   always_comb begin
      case (cfg_q[fpmdc_pkg::FPMDC_B_MODE_LO +: fpmdc_pkg::FPMDC_MODE_W])
         fpmdc_pkg::FPMDC_MODE_ACTIVE: begin
            state_d = fpmdc_pkg::FPMDC_ST_ACTIVE;
         end
         fpmdc_pkg::FPMDC_MODE_STANDBY: begin
            state_d = fpmdc_pkg::FPMDC_ST_STANDBY;
         end
         default: begin
            state_d = fpmdc_pkg::FPMDC_ST_PDOWN;
         end
      endcase
   end

   // Clock source is passed on as a level; a glitch-free changeover lies outside this bank.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_drdy    <= 1'b0;
         o_clk_ext <= 1'b0;
         o_word32  <= 1'b0;
         o_state   <= fpmdc_pkg::FPMDC_ST_ACTIVE;
      end else begin
         o_drdy    <= cfg_q[fpmdc_pkg::FPMDC_B_DRDY] ? i_drdy_b : i_drdy_a;
         o_clk_ext <= cfg_q[fpmdc_pkg::FPMDC_B_CLK];
         o_word32  <= cfg_q[fpmdc_pkg::FPMDC_B_WORD];
         o_state   <= state_d;
      end
   end

   // ======================================================
   // Checks
   AST_MASK_RST: assert property (@(posedge i_clk) $rose(i_rstn) |-> mask_q == fpmdc_pkg::FPMDC_RST_MASK)
      else $error("Mask register reset value wrong");
   AST_CFG_RST: assert property (@(posedge i_clk) $rose(i_rstn) |-> cfg_q == fpmdc_pkg::FPMDC_RST_CFG)
      else $error("Config register reset value wrong");
   AST_STATE_RST: assert property (@(posedge i_clk) $rose(i_rstn) |->
      o_state == fpmdc_pkg::FPMDC_ST_ACTIVE && !o_fault && !o_clk_ext && !o_word32)
      else $error("Outputs not at reset values");
   AST_FAULT: assert property (@(posedge i_clk) disable iff (!i_rstn)
      ##1 o_fault == ($past(i_fault_mode) && |($past(i_flags) & ~$past(mask_fld))))
      else $error("Fault pin disagrees with unmasked flags");

   // Each flag must pass while its mask bit is clear and be held back while it is set.
   AST_SUPPLY: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_fault_mode && i_flags[fpmdc_pkg::FPMDC_F_SUPPLY] && !mask_fld[fpmdc_pkg::FPMDC_F_SUPPLY]) |=> o_fault)
      else $error("Unmasked supply flag missed");
   AST_SUPPLY_BLK: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_flags == (8'h01 << fpmdc_pkg::FPMDC_F_SUPPLY) && mask_fld[fpmdc_pkg::FPMDC_F_SUPPLY]) |=> !o_fault)
      else $error("Masked supply flag reached pin");
   AST_CLOCK_PASS: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_fault_mode && i_flags[fpmdc_pkg::FPMDC_F_CLOCK] && !mask_fld[fpmdc_pkg::FPMDC_F_CLOCK]) |=> o_fault)
      else $error("Unmasked clock flag missed");
   AST_CLOCK_BLK: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_flags == (8'h01 << fpmdc_pkg::FPMDC_F_CLOCK) && mask_fld[fpmdc_pkg::FPMDC_F_CLOCK]) |=> !o_fault)
      else $error("Masked clock flag reached pin");
   AST_DIGITAL_PASS: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_fault_mode && i_flags[fpmdc_pkg::FPMDC_F_DIGITAL] && !mask_fld[fpmdc_pkg::FPMDC_F_DIGITAL]) |=> o_fault)
      else $error("Unmasked digital flag missed");
   AST_DIGITAL_BLK: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_flags == (8'h01 << fpmdc_pkg::FPMDC_F_DIGITAL) && mask_fld[fpmdc_pkg::FPMDC_F_DIGITAL]) |=> !o_fault)
      else $error("Masked digital flag reached pin");
   AST_OVERCUR_PASS: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_fault_mode && i_flags[fpmdc_pkg::FPMDC_F_OVERCUR] && !mask_fld[fpmdc_pkg::FPMDC_F_OVERCUR]) |=> o_fault)
      else $error("Unmasked overcurrent flag missed");
   AST_OVERCUR_BLK: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_flags == (8'h01 << fpmdc_pkg::FPMDC_F_OVERCUR) && mask_fld[fpmdc_pkg::FPMDC_F_OVERCUR]) |=> !o_fault)
      else $error("Masked overcurrent flag reached pin");
   AST_CHECKSUM_PASS: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_fault_mode && i_flags[fpmdc_pkg::FPMDC_F_CHECKSUM] && !mask_fld[fpmdc_pkg::FPMDC_F_CHECKSUM]) |=> o_fault)
      else $error("Unmasked checksum flag missed");
   AST_CHECKSUM_BLK: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_flags == (8'h01 << fpmdc_pkg::FPMDC_F_CHECKSUM) && mask_fld[fpmdc_pkg::FPMDC_F_CHECKSUM]) |=> !o_fault)
      else $error("Masked checksum flag reached pin");
   AST_TIMEOUT_PASS: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_fault_mode && i_flags[fpmdc_pkg::FPMDC_F_TIMEOUT] && !mask_fld[fpmdc_pkg::FPMDC_F_TIMEOUT]) |=> o_fault)
      else $error("Unmasked timeout flag missed");
   AST_TIMEOUT_BLK: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_flags == (8'h01 << fpmdc_pkg::FPMDC_F_TIMEOUT) && mask_fld[fpmdc_pkg::FPMDC_F_TIMEOUT]) |=> !o_fault)
      else $error("Masked timeout flag reached pin");
   AST_SCLKCNT_PASS: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_fault_mode && i_flags[fpmdc_pkg::FPMDC_F_SCLKCNT] && !mask_fld[fpmdc_pkg::FPMDC_F_SCLKCNT]) |=> o_fault)
      else $error("Unmasked clock-count flag missed");
   AST_SCLKCNT_BLK: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_flags == (8'h01 << fpmdc_pkg::FPMDC_F_SCLKCNT) && mask_fld[fpmdc_pkg::FPMDC_F_SCLKCNT]) |=> !o_fault)
      else $error("Masked clock-count flag reached pin");
   AST_ACCESS_PASS: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_fault_mode && i_flags[fpmdc_pkg::FPMDC_F_ACCESS] && !mask_fld[fpmdc_pkg::FPMDC_F_ACCESS]) |=> o_fault)
      else $error("Unmasked access flag missed");
   AST_ACCESS_BLK: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_flags == (8'h01 << fpmdc_pkg::FPMDC_F_ACCESS) && mask_fld[fpmdc_pkg::FPMDC_F_ACCESS]) |=> !o_fault)
      else $error("Masked access flag reached pin");

   // Register contents and read port.
   AST_RSVD: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (mask_q & ~fpmdc_pkg::FPMDC_WMASK_MASK) == 16'h0000 && (cfg_q & ~fpmdc_pkg::FPMDC_WMASK_CFG) == 16'h0000)
      else $error("Reserved bit nonzero");
   AST_RD_MASK: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_rd && fpmdc_hit(i_addr, fpmdc_pkg::FPMDC_ADDR_MASK)) |=> o_rvalid && o_rdata == $past(mask_q))
      else $error("Mask register read wrong");
   AST_RD_CFG: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_rd && fpmdc_hit(i_addr, fpmdc_pkg::FPMDC_ADDR_CFG)) |=> o_rvalid && o_rdata == $past(cfg_q))
      else $error("Config register read wrong");
   AST_RD_UNMAPPED: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_rd && !fpmdc_hit(i_addr, fpmdc_pkg::FPMDC_ADDR_MASK) && !fpmdc_hit(i_addr, fpmdc_pkg::FPMDC_ADDR_CFG))
      |=> o_rvalid && o_rdata == 16'h0000)
      else $error("Unmapped read not zero");

   // Configuration outputs.
   AST_DRDY: assert property (@(posedge i_clk) disable iff (!i_rstn)
      ##1 o_drdy == ($past(cfg_q[fpmdc_pkg::FPMDC_B_DRDY]) ? $past(i_drdy_b) : $past(i_drdy_a)))
      else $error("Data ready source wrong");
   AST_CLKSRC: assert property (@(posedge i_clk) disable iff (!i_rstn)
      ##1 o_clk_ext == $past(cfg_q[fpmdc_pkg::FPMDC_B_CLK]))
      else $error("Clock source not applied");
   AST_MODE: assert property (@(posedge i_clk) disable iff (!i_rstn)
      cfg_q[fpmdc_pkg::FPMDC_B_MODE_LO + 1] |=> o_state == fpmdc_pkg::FPMDC_ST_PDOWN)
      else $error("Power-down not reached");
   AST_STANDBY: assert property (@(posedge i_clk) disable iff (!i_rstn)
      cfg_q[fpmdc_pkg::FPMDC_B_MODE_LO +: fpmdc_pkg::FPMDC_MODE_W] == fpmdc_pkg::FPMDC_MODE_STANDBY
      |=> o_state == fpmdc_pkg::FPMDC_ST_STANDBY)
      else $error("Standby not reached");
   AST_ACTIVE: assert property (@(posedge i_clk) disable iff (!i_rstn)
      cfg_q[fpmdc_pkg::FPMDC_B_MODE_LO +: fpmdc_pkg::FPMDC_MODE_W] == fpmdc_pkg::FPMDC_MODE_ACTIVE
      |=> o_state == fpmdc_pkg::FPMDC_ST_ACTIVE)
      else $error("Active not reached");
   AST_WORD: assert property (@(posedge i_clk) disable iff (!i_rstn)
      cfg_we |=> ##1 o_word32 == $past(i_wdata[fpmdc_pkg::FPMDC_B_WORD], 2))
      else $error("Word length not applied");
endmodule

// ==== src/fpmdc_pkg.sv ====
// Package of constants for the fault-pin mask and device configuration bank.
package fpmdc_pkg;
   // ======================================================
   // Register map
   localparam logic [7:0]  FPMDC_ADDR_MASK  = 8'h4b;
   localparam logic [7:0]  FPMDC_ADDR_CFG   = 8'h4c;
   localparam logic [15:0] FPMDC_RST_MASK   = 16'h0780;
   localparam logic [15:0] FPMDC_RST_CFG    = 16'h0000;
   localparam logic [15:0] FPMDC_WMASK_MASK = 16'h7f80;
   localparam logic [15:0] FPMDC_WMASK_CFG  = 16'h7b00;
   // ======================================================
   // Field positions
   localparam int FPMDC_FLAG_LO   = 7;
   localparam int FPMDC_NFLAG     = 8;
   localparam int FPMDC_B_DRDY    = 14;
   localparam int FPMDC_B_CLK     = 12;
   localparam int FPMDC_B_WORD    = 11;
   localparam int FPMDC_B_MODE_LO = 8;
   localparam int FPMDC_MODE_W    = 2;
   // Flag positions on the summary flag input; mask bit is the flag index plus FPMDC_FLAG_LO.
   localparam int FPMDC_F_SUPPLY   = 7;
   localparam int FPMDC_F_CLOCK    = 6;
   localparam int FPMDC_F_DIGITAL  = 5;
   localparam int FPMDC_F_OVERCUR  = 4;
   localparam int FPMDC_F_CHECKSUM = 3;
   localparam int FPMDC_F_TIMEOUT  = 2;
   localparam int FPMDC_F_SCLKCNT  = 1;
   localparam int FPMDC_F_ACCESS   = 0;
   // ======================================================
   // Operating state field codes
   localparam logic [1:0] FPMDC_MODE_ACTIVE  = 2'h0;
   localparam logic [1:0] FPMDC_MODE_STANDBY = 2'h1;
   // ======================================================
   // Operating states
   typedef enum logic [2:0] {
      FPMDC_ST_ACTIVE  = 3'h1,
      FPMDC_ST_STANDBY = 3'h2,
      FPMDC_ST_PDOWN   = 3'h4
   } fpmdc_state_t;
endpackage

// ==== src/fpmdc_reg.sv ====
// Single masked-write register with reset value, used for both bank registers.
`timescale 1ns/10ps
module fpmdc_reg #(
   parameter logic [15:0] RST   = 16'h0000,
   parameter logic [15:0] WMASK = 16'hffff
) (
   input  wire logic        i_clk,   // Main clock.
   input  wire logic        i_rstn,  // Async reset, active low.
   input  wire logic        i_we,    // Write strobe.
   input  wire logic [15:0] i_wdata, // Write data.
   output logic      [15:0] o_q      // Stored value.
);
   // Only writable bits update, so reserved bits hold their zero reset.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_q <= RST;
      end else if (i_we) begin
         o_q <= (i_wdata & WMASK) | (o_q & ~WMASK);
      end
   end
endmodule

// ==== bench/fpmdc_host.sv ====
// Host-side model that issues register writes and reads.
`timescale 1ns/10ps
module fpmdc_host (
   input  wire logic        i_clk,   // Main clock.
   input  wire logic [15:0] i_rdata, // Read data.
   output logic             o_wr,    // Write strobe.
   output logic             o_rd,    // Read strobe.
   output logic [7:0]       o_addr,  // Address.
   output logic [15:0]      o_wdata  // Write data.
);
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 8'h00;
      o_wdata = 16'h0000;
   end
   // Released data is inverted so a stale value cannot pass for a fresh one.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge i_clk);
      o_wr = 1'b1;
      o_addr = a;
      o_wdata = d;
      @(negedge i_clk);
      o_wr = 1'b0;
      o_wdata = ~d;
      @(negedge i_clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(negedge i_clk);
      o_rd = 1'b1;
      o_addr = a;
      @(negedge i_clk);
      o_rd = 1'b0;
      d = i_rdata;
   endtask
endmodule

// ==== bench/fpmdc_top_bench.sv ====
// Self-checking bench for the mask and configuration bank.
`timescale 1ns/10ps
module fpmdc_top_bench;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        wr, rd, cext, w32, drdy, fault, rv;
   logic        da = 1'b0;
   logic        db = 1'b1;
   logic        fmode = 1'b0;
   logic [7:0]  addr;
   logic [7:0]  flags = 8'h00;
   logic [15:0] wdata, rdata, v;
   logic [2:0]  st;
   int          miscompares = 0;
   int          samples_checked = 0;
   always #2 clk = ~clk;
   fpmdc_host fpmdc_host_inst (.i_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr),
      .o_wdata(wdata));
   fpmdc_top fpmdc_top_inst (.i_clk(clk), .i_rstn(rstn), .i_wr(wr), .i_rd(rd), .i_addr(addr),
      .i_wdata(wdata), .i_flags(flags), .i_fault_mode(fmode), .i_drdy_a(da), .i_drdy_b(db),
      .o_rdata(rdata), .o_rvalid(rv), .o_fault(fault), .o_drdy(drdy), .o_clk_ext(cext),
      .o_word32(w32), .o_state(st));
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [15:0] e);
      fpmdc_host_inst.rd(a, v);
      chk({15'h0, rv}, 16'h0001);
      chk(v, e);
   endtask
   task automatic summarize;
      $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
      if (miscompares == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ==========================================
   // Tests
   initial begin
      repeat (5) @(negedge clk);
      rstn = 1'b1;
      rchk(8'h4b, 16'h0780);
      rchk(8'h4c, 16'h0000);
      fpmdc_host_inst.wr(8'h4c, 16'h0100);
      chk({10'h0, cext, w32, drdy, st}, 16'h0002);
      fpmdc_host_inst.wr(8'h4c, 16'hffff);
      chk({10'h0, cext, w32, drdy, st}, 16'h003c);
      rchk(8'h4c, 16'h7b00);
      fpmdc_host_inst.wr(8'h4c, 16'h0200);
      chk({10'h0, cext, w32, drdy, st}, 16'h0004);
      fpmdc_host_inst.wr(8'h4c, 16'h0000);
      chk({10'h0, cext, w32, drdy, st}, 16'h0001);
      da = 1'b1;
      db = 1'b0;
      repeat (2) @(negedge clk);
      chk({15'h0, drdy}, 16'h0001);
      fpmdc_host_inst.wr(8'h4c, 16'h4000);
      chk({15'h0, drdy}, 16'h0000);
      da = 1'b0;
      db = 1'b1;
      repeat (2) @(negedge clk);
      chk({15'h0, drdy}, 16'h0001);
      fpmdc_host_inst.wr(8'h4b, 16'h0000);
      rstn = 1'b0;
      @(negedge clk);
      chk({10'h0, cext, w32, drdy, st}, 16'h0001);
      rstn = 1'b1;
      rchk(8'h4c, 16'h0000);
      rchk(8'h4b, 16'h0780);
      fpmdc_host_inst.wr(8'h4b, 16'hffff);
      fpmdc_host_inst.wr(8'h4d, 16'h0000);
      rchk(8'h4b, 16'h7f80);
      rchk(8'h4d, 16'h0000);
      fmode = 1'b1;
      for (int i = 0; i < 8; i++) begin
         fpmdc_host_inst.wr(8'h4b, 16'h0000);
         flags = 8'h01 << i;
         @(negedge clk);
         chk({15'h0, fault}, 16'h0001);
         fpmdc_host_inst.wr(8'h4b, 16'h0080 << i);
         chk({15'h0, fault}, 16'h0000);
      end
      fpmdc_host_inst.wr(8'h4b, 16'h0000);
      fmode = 1'b0;
      repeat (2) @(negedge clk);
      chk({15'h0, fault}, 16'h0000);
      summarize();
   end
   initial begin
      #20000;
      miscompares++;
      summarize();
   end
endmodule
